// File: tb/contact_bank.sv
`timescale 1ns/10ps
// ---------------------------------------------------------------
// external contacts
// ---------------------------------------------------------------
// closed contact applies supply, open one leaves the pull-down,
// so an open input reads 0, never the last level
module contact_bank (
  input wire logic aclk,
  input wire logic [7:0] close_req,
  output logic [7:0] din
);
  // contacts move only at edges so bench timing stays exact
  always_ff @(posedge aclk) begin
    din <= close_req;
  end
endmodule

// File: tb/digital_input_event_handler_test.sv
`timescale 1ns/10ps
module digital_input_event_handler_test;
  // ---------------------------------------------------------------
  // signals
  // ---------------------------------------------------------------
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] close_req = 8'h00;
  logic [7:0] din;
  logic wait_step = 1'b0;
  logic [3:0] wait_sel = 4'h0;
  din_pkg::seq_cmd_t seq_cmd;
  logic wait_release;
  din_pkg::out_ovr_t ovr;
  logic [7:0] evt_ctrl;
  din_pkg::prg_state_t prg_state;
  logic [7:0] s_axi_awaddr = 8'h00;
  logic [7:0] s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'b0;
  logic s_axi_wvalid = 1'b0;
  logic s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0;
  logic s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata, rd;
  logic [1:0] rs;
  logic [7:0] mode;
  logic [3:0] fc;
  int num_errors = 0;
  int num_checks = 0;
  int seed = 32'h8F76;
  int cnt [8];

  always #25 aclk = ~aclk;

  contact_bank u_contact_bank (.aclk, .close_req, .din);

  digital_input_event_handler u_digital_input_event_handler (
    .aclk, .aresetn, .din, .wait_step, .wait_sel, .seq_cmd,
    .wait_release, .ovr, .evt_ctrl, .prg_state, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready
  );

  // pulse counters: bit 7 is the wait release, 6..0 the commands
  always @(posedge aclk) begin
    for (int k = 0; k < 7; k++) if (seq_cmd[k]) cnt[k] <= cnt[k] + 1;
    if (wait_release) cnt[7] <= cnt[7] + 1;
  end

  // ---------------------------------------------------------------
  // tasks
  // ---------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] seen, exp);
    num_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // a repeated pulse shows as x so it can never match
  function automatic logic [7:0] pulses();
    logic [7:0] g;
    for (int k = 0; k < 8; k++) g[k] = cnt[k] == 0 ? 1'b0 :
      (cnt[k] == 1 ? 1'b1 : 1'bx);
    return g;
  endfunction

  task automatic complete_run();
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    rs = s_axi_bresp;
    s_axi_bready <= 1'b0;
    @(posedge aclk);
  endtask

  task automatic rdr(input logic [7:0] a);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    rd = s_axi_rdata;
    rs = s_axi_rresp;
    s_axi_rready <= 1'b0;
    @(posedge aclk);
  endtask

  // flip input i, hold it, flip back; check pulses and state
  task automatic fire(input int i, input logic [7:0] e, m,
                      input din_pkg::prg_state_t s);
    for (int k = 0; k < 8; k++) cnt[k] = 0;
    close_req[i] <= ~close_req[i];
    repeat (6) @(posedge aclk);
    chk("pulses on", pulses() & m, e);
    chk("state", 32'(prg_state), 32'(s));
    for (int k = 0; k < 8; k++) cnt[k] = 0;
    close_req[i] <= ~close_req[i];
    repeat (6) @(posedge aclk);
    chk("pulses off", pulses(), 8'h00);
  endtask

  // ---------------------------------------------------------------
  // sequence
  // ---------------------------------------------------------------
  initial begin
    repeat (20000) @(posedge aclk);
    num_errors++;
    complete_run();
  end

  initial begin
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    chk("reset outs", 32'({seq_cmd, wait_release, ovr, evt_ctrl,
        prg_state, s_axi_bvalid, s_axi_rvalid}), 32'h0);
    @(posedge aclk);
    rdr(din_pkg::ADDR_MODE);
    chk("mode reset", rd, din_pkg::MODE_RESET);
    rdr(din_pkg::ADDR_FUNC_LO);
    chk("func reset", rd, din_pkg::FUNC_RESET);
    rdr(8'h20);
    chk("unmapped rd", {rd[29:0], rs}, 32'(din_pkg::RESP_SLVERR));
    wr(8'h24, 32'hFFFF_FFFF);
    chk("unmapped wr", 32'(rs), 32'(din_pkg::RESP_SLVERR));
    wr(din_pkg::ADDR_FUNC_LO, 32'h8765_4321);
    rdr(din_pkg::ADDR_FUNC_LO);
    chk("func readback", rd, 32'h8765_4321);
    s_axi_wstrb <= 4'h6;
    wr(din_pkg::ADDR_FUNC_HI, 32'hA5C3_9E71);
    chk("wr resp", 32'(rs), 32'(din_pkg::RESP_OKAY));
    s_axi_wstrb <= 4'hF;
    rdr(din_pkg::ADDR_FUNC_HI);
    chk("strobe lanes", rd, 32'h00C3_9E00);
    fire(3, 8'h00, 8'hFF, din_pkg::PRG_IDLE);
    fire(1, 8'h00, 8'hFF, din_pkg::PRG_IDLE);
    fire(2, 8'h00, 8'hFF, din_pkg::PRG_IDLE);
    fire(6, 8'h00, 8'hFF, din_pkg::PRG_IDLE);
    fire(0, 8'h40, 8'hFF, din_pkg::PRG_RUN);
    fire(0, 8'h00, 8'hFF, din_pkg::PRG_RUN);
    rdr(din_pkg::ADDR_PRG);
    chk("prg reg", rd, 32'(din_pkg::PRG_RUN));
    fire(2, 8'h00, 8'hFF, din_pkg::PRG_RUN);
    fire(5, 8'h00, 8'hFF, din_pkg::PRG_RUN);
    fire(4, 8'h00, 8'hFF, din_pkg::PRG_RUN);
    fire(1, 8'h20, 8'hFF, din_pkg::PRG_HOLD);
    fire(6, 8'h02, 8'hFF, din_pkg::PRG_HOLD);
    fire(5, 8'h01, 8'hFF, din_pkg::PRG_HOLD);
    fire(0, 8'h10, 8'hFF, din_pkg::PRG_RUN);
    fire(1, 8'h20, 8'hFF, din_pkg::PRG_HOLD);
    fire(2, 8'h10, 8'hFF, din_pkg::PRG_RUN);
    wait_sel <= 4'h4;
    wait_step <= 1'b1;
    repeat (4) @(posedge aclk);
    chk("wait entry", 32'(prg_state), 32'(din_pkg::PRG_WAIT));
    wait_step <= 1'b0;
    @(posedge aclk);
    fire(4, 8'h80, 8'hFF, din_pkg::PRG_RUN);
    fire(3, 8'h0C, 8'hFF, din_pkg::PRG_IDLE);
    wr(din_pkg::ADDR_MODE, 32'h0000_00FE);
    close_req[0] <= 1'b1;
    repeat (6) @(posedge aclk);
    chk("no rise fire", 32'(prg_state), 32'(din_pkg::PRG_IDLE));
    fire(0, 8'h40, 8'hFF, din_pkg::PRG_RUN);
    fire(3, 8'h0C, 8'hFF, din_pkg::PRG_IDLE);
    // in7 falling mode: open contact means the input is on
    wr(din_pkg::ADDR_MODE, 32'h0000_007F);
    for (int c = 8; c < 13; c++) begin
      fc = 4'(c % 12);
      wr(din_pkg::ADDR_FUNC_LO, {fc, 28'h765_4321});
      close_req[7] <= 1'b0;
      repeat (4) @(posedge aclk);
      chk("ovr on", 32'({ovr, evt_ctrl[7]}), 32'({fc == 4'h8 ||
          fc == 4'h9, fc == 4'h9 || fc == 4'hA, fc == 4'hB}));
      close_req[7] <= 1'b1;
      repeat (4) @(posedge aclk);
      chk("ovr off", 32'({ovr, evt_ctrl}), 32'h0);
    end
    wr(din_pkg::ADDR_FUNC_LO, 32'hBBBB_BBBB);
    for (int t = 0; t < 40; t++) begin
      mode = 8'($random(seed));
      wr(din_pkg::ADDR_MODE, {24'h0, mode});
      close_req <= 8'($random(seed));
      repeat (4) @(posedge aclk);
      chk("evt ctrl", {24'h0, evt_ctrl}, {24'h0, ~(din ^ mode)});
      chk("ovr idle", 32'(ovr), 32'h0);
      rdr(din_pkg::ADDR_STATUS);
      chk("status", rd, {16'h0, ~(din ^ mode), din});
    end
    complete_run();
  end
endmodule

// File: verilog/digital_input_event_handler.sv
`timescale 1ns/10ps
// Notes on behaviour
// RQ1: eight inputs, each with its own transition mode and function.
// RQ2: each input fires on rising or falling edge per its mode bit.
// RQ3: level functions see on as high in rising mode, low in falling.
// RQ4: one function code per input; inactive code disables the input.
// RQ5: run edge starts program at step one when idle; no action in run or wait.
// RQ6: run edge during hold returns program to run, no restart.
// RQ7: hold edge holds a running program; ignored when not running.
// RQ8: continue edge resumes a held program; ignored otherwise.
// RQ9: end edge stops program, clears events; nothing when idle.
// RQ10: single-shot functions act once per qualifying edge only.
// RQ11: wait function triggers the sequencer's wait-for-input step.
// RQ12: wait edges before the wait state are discarded.
// RQ13: step forward/back move one step only if held before input on.
// RQ14: chamber-outputs-off input on forces chamber outputs off.
// RQ15: all-outputs-off forces chamber and event outputs off.
// RQ16: event-outputs-off forces customer event outputs off.
// RQ17: event-output-control passes input on state to its outputs.
// RQ18: several inputs may share a function; conflicts are software's.
// RQ19: inputs registered; edge by comparing sample with previous.
module digital_input_event_handler #(
  parameter int N = din_pkg::NUM_INPUTS
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [N-1:0] din,
  input wire logic wait_step,
  input wire logic [3:0] wait_sel,
  output din_pkg::seq_cmd_t seq_cmd,
  output logic wait_release,
  output din_pkg::out_ovr_t ovr,
  output logic [N-1:0] evt_ctrl,
  output din_pkg::prg_state_t prg_state,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);

  // ---------------------------------------------------------------
  // functions
  // ---------------------------------------------------------------
  function automatic din_pkg::din_func_t func_of(
    input logic [63:0] f, input int i);
    func_of = din_pkg::din_func_t'(f[i*din_pkg::FUNC_W +: din_pkg::FUNC_W]);
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old,
    input logic [31:0] nw, input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        r[b*8 +: 8] = nw[b*8 +: 8];
      end
    end
    merge = r;
  endfunction

  // ---------------------------------------------------------------
  // configuration registers
  // ---------------------------------------------------------------
  logic [31:0] mode_q;
  logic [63:0] func_q;
  logic [7:0] awaddr_q;
  logic aw_held_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic w_held_q;
  logic do_write;

  assign do_write = aw_held_q && w_held_q && !s_axi_bvalid;

  // address and data taken in either order, response after both
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_q <= 1'b0;
      w_held_q <= 1'b0;
      awaddr_q <= 8'h00;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= din_pkg::RESP_OKAY;
    end else begin
      s_axi_awready <= !aw_held_q && !s_axi_awready && s_axi_awvalid;
      s_axi_wready <= !w_held_q && !s_axi_wready && s_axi_wvalid;
      if (s_axi_awready && s_axi_awvalid) begin
        aw_held_q <= 1'b1;
        awaddr_q <= s_axi_awaddr;
      end
      if (s_axi_wready && s_axi_wvalid) begin
        w_held_q <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
      if (do_write) begin
        aw_held_q <= 1'b0;
        w_held_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        unique case (awaddr_q)
          din_pkg::ADDR_MODE, din_pkg::ADDR_FUNC_LO,
          din_pkg::ADDR_FUNC_HI: s_axi_bresp <= din_pkg::RESP_OKAY;
          default: s_axi_bresp <= din_pkg::RESP_SLVERR;
        endcase
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mode_q <= din_pkg::MODE_RESET;
      func_q <= {din_pkg::FUNC_RESET, din_pkg::FUNC_RESET};
    end else if (do_write) begin
      unique case (awaddr_q)
        din_pkg::ADDR_MODE: mode_q <= merge(mode_q, wdata_q, wstrb_q);
        din_pkg::ADDR_FUNC_LO:
          func_q[31:0] <= merge(func_q[31:0], wdata_q, wstrb_q); // [RQ4]
        din_pkg::ADDR_FUNC_HI:
          func_q[63:32] <= merge(func_q[63:32], wdata_q, wstrb_q);
        default: ;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // input sampling and edges
  // ---------------------------------------------------------------
  logic [N-1:0] samp_q;
  logic [N-1:0] prev_q;
  logic [N-1:0] on_lvl;
  logic [N-1:0] fire;

  // inputs are taken as synchronous; one sample stage plus history
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      samp_q <= '0;
      prev_q <= '0;
    end else begin
      samp_q <= din; // [RQ19]
      prev_q <= samp_q;
    end
  end

  // high mode bit: on = voltage present; low mode: on = voltage absent
  assign on_lvl = ~(samp_q ^ mode_q[N-1:0]) ; // [RQ3]
  // the edge into the on state is the configured transition
  assign fire = (samp_q ^ prev_q) & on_lvl; // [RQ2] [RQ10] [RQ19]

  // ---------------------------------------------------------------
  // function decode
  // ---------------------------------------------------------------
  logic f_run, f_hold, f_cont, f_end, f_fwd, f_back;
  logic [N-1:0] f_wait;
  logic l_cham, l_all, l_evt;
  logic [N-1:0] l_ctrl;

  // several inputs may share a function; their effects OR, except wait and event control, which stay per input
  always_comb begin
    f_run = 1'b0;
    f_hold = 1'b0;
    f_cont = 1'b0;
    f_end = 1'b0;
    f_fwd = 1'b0;
    f_back = 1'b0;
    f_wait = '0;
    l_cham = 1'b0;
    l_all = 1'b0;
    l_evt = 1'b0;
    l_ctrl = '0;
    for (int i = 0; i < N; i++) begin // [RQ1] [RQ18]
      unique case (func_of(func_q, i))
        din_pkg::FN_INACTIVE: ; // [RQ4]
        din_pkg::FN_RUN: f_run = f_run | fire[i];
        din_pkg::FN_HOLD: f_hold = f_hold | fire[i];
        din_pkg::FN_CONTINUE: f_cont = f_cont | fire[i];
        din_pkg::FN_END: f_end = f_end | fire[i];
        din_pkg::FN_WAIT: f_wait[i] = fire[i]; // [RQ11]
        din_pkg::FN_STEP_BACK: f_back = f_back | fire[i];
        din_pkg::FN_STEP_FWD: f_fwd = f_fwd | fire[i];
        din_pkg::FN_CHAMBER_OFF: l_cham = l_cham | on_lvl[i]; // [RQ14]
        din_pkg::FN_ALL_OFF: l_all = l_all | on_lvl[i]; // [RQ15]
        din_pkg::FN_EVENT_OFF: l_evt = l_evt | on_lvl[i]; // [RQ16]
        din_pkg::FN_EVENT_CTRL: l_ctrl[i] = on_lvl[i]; // [RQ17]
        default: ;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // program state tracking and commands
  // ---------------------------------------------------------------
  din_pkg::prg_state_t prg_d;
  din_pkg::seq_cmd_t cmd_d;
  logic wait_hit;

  // only an edge seen while waiting counts; earlier ones are gone
  assign wait_hit = (prg_state == din_pkg::PRG_WAIT) &&
    f_wait[wait_sel[2:0]]; // [RQ12]

  // end has priority over run, hold, continue in one cycle
  always_comb begin
    prg_d = prg_state;
    cmd_d = '0;
    if (wait_step && prg_state == din_pkg::PRG_RUN) begin
      prg_d = din_pkg::PRG_WAIT;
    end
    if (f_end && prg_state != din_pkg::PRG_IDLE) begin // [RQ9]
      cmd_d.stop = 1'b1;
      cmd_d.clear_events = 1'b1;
      prg_d = din_pkg::PRG_IDLE;
    end else begin
      unique case (prg_state)
        din_pkg::PRG_IDLE: begin
          if (f_run) begin // [RQ5]
            cmd_d.start = 1'b1;
            prg_d = din_pkg::PRG_RUN;
          end
        end
        din_pkg::PRG_HOLD: begin
          if (f_run || f_cont) begin // [RQ6] [RQ8]
            cmd_d.resume = 1'b1;
            prg_d = din_pkg::PRG_RUN;
          end else begin
            cmd_d.step_fwd = f_fwd; // [RQ13]
            cmd_d.step_back = f_back && !f_fwd; // [RQ13]
          end
        end
        din_pkg::PRG_RUN, din_pkg::PRG_WAIT: begin
          if (f_hold) begin // [RQ7]
            cmd_d.hold = 1'b1;
            prg_d = din_pkg::PRG_HOLD;
          end else if (wait_hit) begin // [RQ11]
            prg_d = din_pkg::PRG_RUN;
          end
        end
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      prg_state <= din_pkg::PRG_IDLE;
      seq_cmd <= '0;
      wait_release <= 1'b0;
    end else begin
      prg_state <= prg_d;
      seq_cmd <= cmd_d; // [RQ10]
      wait_release <= wait_hit && !f_hold && !f_end;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ovr <= '0;
      evt_ctrl <= '0;
    end else begin
      ovr.chamber_off <= l_cham | l_all; // [RQ14] [RQ15]
      ovr.event_off <= l_evt | l_all; // [RQ15] [RQ16]
      evt_ctrl <= l_ctrl; // [RQ17]
    end
  end

  // ---------------------------------------------------------------
  // read channel
  // ---------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= din_pkg::RESP_OKAY;
    end else begin
      s_axi_arready <= !s_axi_rvalid && !s_axi_arready && s_axi_arvalid;
      if (s_axi_arready && s_axi_arvalid) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= din_pkg::RESP_OKAY;
        unique case (s_axi_araddr)
          din_pkg::ADDR_MODE: s_axi_rdata <= mode_q;
          din_pkg::ADDR_FUNC_LO: s_axi_rdata <= func_q[31:0];
          din_pkg::ADDR_FUNC_HI: s_axi_rdata <= func_q[63:32];
          din_pkg::ADDR_STATUS:
            s_axi_rdata <= {16'h0000, 8'(on_lvl), 8'(samp_q)};
          din_pkg::ADDR_PRG: s_axi_rdata <= {30'h0, prg_state};
          din_pkg::ADDR_OVR:
            s_axi_rdata <= {22'h0, 8'(evt_ctrl), ovr};
          default: begin
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= din_pkg::RESP_SLVERR;
          end
        endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  logic [N-1:0] ctrl_sel;

  // own decode of the pass-through inputs, so the check is not circular
  always_comb begin
    ctrl_sel = '0;
    for (int i = 0; i < N; i++) begin
      ctrl_sel[i] = func_of(func_q, i) == din_pkg::FN_EVENT_CTRL;
    end
  end

  default clocking chk_cb @(posedge aclk);
  endclocking

  default disable iff (!aresetn);

  sequence s_held;
    prg_state == din_pkg::PRG_HOLD;
  endsequence

  // a command is one cycle wide, never a level
  sequence s_pulse(sig);
    sig ##1 !sig;
  endsequence

  AST_RUN_START: assert property ( // [RQ5]
    (prg_state == din_pkg::PRG_IDLE && f_run && !f_end)
      |=> prg_state == din_pkg::PRG_RUN ##0 s_pulse(seq_cmd.start))
    else $error("run edge did not start idle program");

  AST_RUN_RESUME: assert property ( // [RQ6]
    (s_held and (f_run && !f_end)) |=> seq_cmd.resume && !seq_cmd.start)
    else $error("run edge in hold did not resume");

  AST_HOLD_IDLE: assert property ( // [RQ7]
    prg_state == din_pkg::PRG_IDLE |=> !seq_cmd.hold)
    else $error("hold issued with no program");

  AST_CONT_ONLY_HELD: assert property ( // [RQ8]
    seq_cmd.resume |-> $past(prg_state) == din_pkg::PRG_HOLD)
    else $error("resume without hold");

  AST_END_IDLE: assert property ( // [RQ9]
    seq_cmd.clear_events |-> $past(prg_state) != din_pkg::PRG_IDLE)
    else $error("events cleared with no program");

  AST_ONE_SHOT: assert property ( // [RQ10]
    $stable(samp_q)[*2] |=> seq_cmd == '0)
    else $error("command without input edge");

  AST_WAIT_EARLY: assert property ( // [RQ12]
    wait_release |-> $past(prg_state) == din_pkg::PRG_WAIT)
    else $error("wait released outside wait state");

  AST_STEP_HELD: assert property ( // [RQ13]
    (seq_cmd.step_fwd || seq_cmd.step_back)
      |-> $past(prg_state) == din_pkg::PRG_HOLD)
    else $error("step change outside hold");

  AST_CHAMBER_OFF: assert property ( // [RQ14]
    l_cham |=> ovr.chamber_off)
    else $error("chamber-off input did not force chamber outputs");

  AST_EVT_OFF: assert property ( // [RQ16]
    l_evt && !l_cham && !l_all |=> ovr.event_off && !ovr.chamber_off)
    else $error("event-off input did not force only event outputs");

  AST_ALL_OFF: assert property ( // [RQ15]
    l_all |=> ovr.chamber_off && ovr.event_off)
    else $error("all-off did not force both groups");

  AST_EVT_CTRL: assert property ( // [RQ17]
    ##1 evt_ctrl == $past(ctrl_sel & on_lvl))
    else $error("event control output lags input");

endmodule

// File: verilog/din_pkg.sv
package din_pkg;

  localparam int NUM_INPUTS = 8;
  localparam int FUNC_W = 4;
  localparam int NUM_DOUT = 15;

  // function codes per input
  typedef enum logic [3:0] {
    FN_INACTIVE   = 4'h0,
    FN_RUN        = 4'h1,
    FN_HOLD       = 4'h2,
    FN_CONTINUE   = 4'h3,
    FN_END        = 4'h4,
    FN_WAIT       = 4'h5,
    FN_STEP_BACK  = 4'h6,
    FN_STEP_FWD   = 4'h7,
    FN_CHAMBER_OFF = 4'h8,
    FN_ALL_OFF    = 4'h9,
    FN_EVENT_OFF  = 4'hA,
    FN_EVENT_CTRL = 4'hB
  } din_func_t;

  // program sequencer state
  typedef enum logic [1:0] {
    PRG_IDLE = 2'h0,
    PRG_RUN  = 2'h1,
    PRG_HOLD = 2'h2,
    PRG_WAIT = 2'h3
  } prg_state_t;

  // register byte addresses
  localparam logic [7:0] ADDR_MODE = 8'h00;
  localparam logic [7:0] ADDR_FUNC_LO = 8'h04;
  localparam logic [7:0] ADDR_FUNC_HI = 8'h08;
  localparam logic [7:0] ADDR_STATUS = 8'h0C;
  localparam logic [7:0] ADDR_PRG = 8'h10;
  localparam logic [7:0] ADDR_OVR = 8'h14;

  localparam logic [31:0] MODE_RESET = 32'h0000_00FF;
  localparam logic [31:0] FUNC_RESET = 32'h0000_0000;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // sequencer commands, one-cycle pulses to the program sequencer
  typedef struct packed {
    logic start;
    logic hold;
    logic resume;
    logic stop;
    logic clear_events;
    logic step_fwd;
    logic step_back;
  } seq_cmd_t;

  // level-held output overrides
  typedef struct packed {
    logic chamber_off;
    logic event_off;
  } out_ovr_t;

endpackage
